// ==== bdsc_top.sv ====
// serial control, angle vector lookup and output gating of the beamform source driver
// assumes the host stops SCK while CS_N is high and keeps CS_N high at least 50 ns between frames
//
// Notes on behaviour
// - frame is 16 bits: command, amplitude msb first, angle msb first
// - command 00 writes, 01 reads back, 10 powers down, 11 only powers up
// - command 10 at select rise powers down, any other command powers up
// - angle code indexes 48 sine/cosine steps of 7.5 degrees
// - 8-bit amplitude code scales output as fraction of 255
// - amplitude and angle may be updated every scan line
// - serial output changes on falling serial clock edge
// - enable fall turns outputs off at once, rise after long settling
// - select is active low, its rise latches a write frame into buffer
// - dac load rise copies buffer into dac data register
// - while enable is low both sink outputs are driven low and SINK_OE is low
`timescale 1ns/10ps
`include "bdsc_defines.svh"

module bdsc_top (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SERIAL_IN,
  output logic SERIAL_OUT,
  input wire logic DAC_LOAD_STROBE,
  input wire logic ENABLE,
  input wire logic INPHASE_DRIVE_A,
  input wire logic INPHASE_DRIVE_B,
  input wire logic QUAD_DRIVE_A,
  input wire logic QUAD_DRIVE_B,
  output logic SINK_OUT_A,
  output logic SINK_OUT_B,
  output logic SINK_OE,
  output logic [7:0] AMPLITUDE,
  output bdsc_pkg::bdsc_vec_t VECTOR,
  output logic POWER_DOWN
);

  localparam logic [11:0] EN_ON_CYCLES = 12'(`BDSC_EN_ON_CYCLES);

  // link domain: reset is carried over by two flops since SCK may stand still
  logic rst_l1;
  logic rst_l2;
  logic [3:0] bit_count;
  logic [15:0] shift_in;
  logic [15:0] readback;

  always_ff @(posedge SCK) begin
    rst_l1 <= RST;
    rst_l2 <= rst_l1;
  end

  always_ff @(posedge SCK) begin
    if (rst_l2) begin
      bit_count <= 4'h0;
      shift_in <= 16'h0000;
    end else if (!CS_N) begin
      shift_in <= {shift_in[14:0], SERIAL_IN};
      bit_count <= bit_count + 4'h1;
    end
  end

  // readback word is static during frames, it only changes after a select rise
  always_ff @(negedge SCK) begin
    if (rst_l2) begin
      SERIAL_OUT <= 1'b0;
    end else if (!CS_N) begin
      SERIAL_OUT <= readback[4'hF - bit_count];
    end
  end

  // core domain: all pins pass two flops
  logic [6:0] pin_s1;
  logic [6:0] pin_s2;
  logic [6:0] pin_d;
  logic cs_rise;
  logic ld_rise;
  logic en_fall;
  logic en_rise;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pin_s1 <= 7'h01;
      pin_s2 <= 7'h01;
      pin_d <= 7'h01;
    end else begin
      pin_s1 <= {QUAD_DRIVE_B, QUAD_DRIVE_A, INPHASE_DRIVE_B, INPHASE_DRIVE_A, ENABLE, DAC_LOAD_STROBE, CS_N};
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end

  assign cs_rise = pin_s2[0] && !pin_d[0];
  assign ld_rise = pin_s2[1] && !pin_d[1];
  assign en_rise = pin_s2[2] && !pin_d[2];
  assign en_fall = !pin_s2[2] && pin_d[2];

  bdsc_pkg::bdsc_frame_t frame;
  bdsc_pkg::bdsc_frame_t buffer;
  logic [7:0] dac_amp;
  logic [5:0] dac_ang;

  // shift_in is quasi-static here: SCK is idle while the select is high
  assign frame = shift_in;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      buffer.cmd <= bdsc_pkg::BDSC_CMD_NOP;
      buffer.amplitude_code <= `BDSC_AMP_RESET;
      buffer.steering_angle <= `BDSC_ANG_RESET;
    end else if (cs_rise && frame.cmd == bdsc_pkg::BDSC_CMD_WRITE) begin
      buffer <= frame;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      readback <= 16'h0000;
    end else if (cs_rise && frame.cmd == bdsc_pkg::BDSC_CMD_READ) begin
      readback <= {bdsc_pkg::BDSC_CMD_READ, buffer.amplitude_code, buffer.steering_angle};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      POWER_DOWN <= 1'b0;
    end else if (cs_rise) begin
      POWER_DOWN <= (frame.cmd == bdsc_pkg::BDSC_CMD_PDOWN);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      dac_amp <= `BDSC_AMP_RESET;
      dac_ang <= `BDSC_ANG_RESET;
    end else if (ld_rise) begin
      dac_amp <= buffer.amplitude_code;
      dac_ang <= buffer.steering_angle;
    end
  end

  // first-quadrant magnitudes, 63 * cos(k * 7.5 deg) rounded
  function automatic logic [5:0] quad_mag(input logic [3:0] k);
    case (k)
      4'h0: quad_mag = 6'h3F;
      4'h1: quad_mag = 6'h3E;
      4'h2: quad_mag = 6'h3D;
      4'h3: quad_mag = 6'h3A;
      4'h4: quad_mag = 6'h37;
      4'h5: quad_mag = 6'h32;
      4'h6: quad_mag = 6'h2D;
      4'h7: quad_mag = 6'h26;
      4'h8: quad_mag = 6'h20;
      4'h9: quad_mag = 6'h18;
      4'hA: quad_mag = 6'h10;
      4'hB: quad_mag = 6'h08;
      default: quad_mag = 6'h00;
    endcase
  endfunction : quad_mag

  logic [5:0] ang_eff;
  logic [1:0] quadrant;
  logic [3:0] step;
  bdsc_pkg::bdsc_vec_t next_vector;

  // reserved codes from 48 upward fall back to zero degrees
  assign ang_eff = (dac_ang >= 6'(`BDSC_ANG_STEPS)) ? 6'h00 : dac_ang;

  always_comb begin
    quadrant = 2'(ang_eff / 6'(`BDSC_QUAD_STEPS));
    step = 4'(ang_eff % 6'(`BDSC_QUAD_STEPS));
    case (quadrant)
      2'h0: begin
        next_vector = {1'b0, quad_mag(step), 1'b0, quad_mag(4'hC - step)};
      end
      2'h1: begin
        next_vector = {1'b1, quad_mag(4'hC - step), 1'b0, quad_mag(step)};
      end
      2'h2: begin
        next_vector = {1'b1, quad_mag(step), 1'b1, quad_mag(4'hC - step)};
      end
      default: begin
        next_vector = {1'b0, quad_mag(4'hC - step), 1'b1, quad_mag(step)};
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      VECTOR <= {1'b0, `BDSC_VEC_FULL, 1'b0, 6'h00};
      AMPLITUDE <= `BDSC_AMP_RESET;
    end else begin
      VECTOR <= next_vector;
      AMPLITUDE <= dac_amp;
    end
  end

  // enable settling: off is immediate, on waits the full settling interval
  bdsc_pkg::bdsc_en_state_t en_state;
  logic [11:0] settle_count;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      en_state <= bdsc_pkg::BDSC_EN_OFF;
      settle_count <= 12'h000;
    end else if (en_fall || !pin_s2[2]) begin
      en_state <= bdsc_pkg::BDSC_EN_OFF;
      settle_count <= 12'h000;
    end else begin
      case (en_state)
        bdsc_pkg::BDSC_EN_OFF: begin
          if (en_rise || pin_s2[2]) begin
            en_state <= bdsc_pkg::BDSC_EN_SETTLE;
            settle_count <= 12'h000;
          end
        end
        bdsc_pkg::BDSC_EN_SETTLE: begin
          settle_count <= settle_count + 12'h001;
          if (settle_count == EN_ON_CYCLES - 12'h001) begin
            en_state <= bdsc_pkg::BDSC_EN_ON;
          end
        end
        default: begin
          en_state <= bdsc_pkg::BDSC_EN_ON;
        end
      endcase
    end
  end

  logic active;
  logic [1:0] drive_on;
  logic [1:0] sink;

  assign active = (en_state == bdsc_pkg::BDSC_EN_ON) && !POWER_DOWN;

  // channel a uses in-phase a and quadrature a, channel b the b pair
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_sink
      assign drive_on[ch] = pin_s2[3 + ch] || pin_s2[5 + ch];
      always_ff @(posedge CORE_CLK) begin
        if (RST) begin
          sink[ch] <= 1'b0;
        end else begin
          sink[ch] <= active && drive_on[ch];
        end
      end
    end
  endgenerate

  assign SINK_OUT_A = sink[0];
  assign SINK_OUT_B = sink[1];

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      SINK_OE <= 1'b0;
    end else begin
      SINK_OE <= active;
    end
  end

endmodule : bdsc_top

// ==== bdsc_defines.svh ====
// constants of the beamform driver serial control block
// assumes a 100 MHz core clock and a 16-bit serial frame
`ifndef BDSC_DEFINES_SVH
`define BDSC_DEFINES_SVH

`define BDSC_FRAME_BITS 16
`define BDSC_CMD_MSB 15
`define BDSC_CMD_LSB 14
`define BDSC_AMP_MSB 13
`define BDSC_AMP_LSB 6
`define BDSC_ANG_MSB 5
`define BDSC_ANG_LSB 0
`define BDSC_ANG_STEPS 48
`define BDSC_QUAD_STEPS 12
`define BDSC_VEC_FULL 6'h3F

`define BDSC_AMP_RESET 8'h00
`define BDSC_ANG_RESET 6'h00

`define BDSC_CLK_PERIOD_NS 10
`define BDSC_EN_ON_NS 20000
`define BDSC_EN_ON_CYCLES (`BDSC_EN_ON_NS / `BDSC_CLK_PERIOD_NS)

`endif

// ==== bdsc_pkg.sv ====
// types shared by the beamform driver serial control block
// assumes bdsc_defines.svh holds the field positions
package bdsc_pkg;

  typedef enum logic [1:0] {
    BDSC_CMD_WRITE = 2'h0,
    BDSC_CMD_READ = 2'h1,
    BDSC_CMD_PDOWN = 2'h2,
    BDSC_CMD_NOP = 2'h3
  } bdsc_cmd_t;

  typedef struct packed {
    bdsc_cmd_t cmd;
    logic [7:0] amplitude_code;
    logic [5:0] steering_angle;
  } bdsc_frame_t;

  typedef struct packed {
    logic i_neg;
    logic [5:0] i_mag;
    logic q_neg;
    logic [5:0] q_mag;
  } bdsc_vec_t;

  // gray sequence along off -> settle -> on
  typedef enum logic [1:0] {
    BDSC_EN_OFF = 2'h0,
    BDSC_EN_SETTLE = 2'h1,
    BDSC_EN_ON = 2'h3
  } bdsc_en_state_t;

endpackage : bdsc_pkg

// ==== bdsc_sva.sv ====
// port checker of the beamform driver serial control block
// assumes it is bound to bdsc_top, core clock domain only
`timescale 1ns/10ps
module bdsc_sva (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic DAC_LOAD_STROBE,
  input wire logic ENABLE,
  input wire logic INPHASE_DRIVE_A,
  input wire logic QUAD_DRIVE_A,
  input wire logic SERIAL_OUT,
  input wire logic SINK_OUT_A,
  input wire logic SINK_OUT_B,
  input wire logic SINK_OE,
  input wire logic [7:0] AMPLITUDE,
  input wire logic POWER_DOWN
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  logic [11:0] en_cnt;
  logic pa;
  assign pa = INPHASE_DRIVE_A | QUAD_DRIVE_A;
  // saturates so a long enable never wraps back under the settling count
  always_ff @(posedge CORE_CLK) begin
    if (RST || !ENABLE)
      en_cnt <= 12'h000;
    else if (en_cnt != 12'hFFF)
      en_cnt <= en_cnt + 12'h001;
  end
  chk_en_settle: assert property (SINK_OE && ENABLE |-> en_cnt >= 12'h7D0)
    else $error("on too early");
  chk_en_on: assert property (en_cnt == 12'h7DA && !POWER_DOWN |-> SINK_OE)
    else $error("on too late");
  chk_en_off: assert property (!ENABLE [*5] |-> !SINK_OE)
    else $error("not off");
  chk_pd_off: assert property (POWER_DOWN [*3] |-> !SINK_OE)
    else $error("driven in power down");
  chk_gate_sinks: assert property (!SINK_OE |-> !SINK_OUT_A && !SINK_OUT_B)
    else $error("sink while off");
  chk_pwm_a: assert property (SINK_OE && $past(SINK_OE) |-> SINK_OUT_A == $past(pa, 3))
    else $error("sink a timing");
  chk_load_amp: assert property ($changed(AMPLITUDE) |->
    $past(DAC_LOAD_STROBE, 3) || $past(DAC_LOAD_STROBE, 4) || $past(DAC_LOAD_STROBE, 5))
    else $error("amplitude without load");
  chk_pd_at_cs: assert property ($changed(POWER_DOWN) |-> CS_N && $past(CS_N))
    else $error("power down mid frame");
  chk_sdo_edge: assert property (SCK |-> $stable(SERIAL_OUT))
    else $error("serial out moved");
  cover property ($rose(SINK_OE));
  cover property ($rose(POWER_DOWN));
  cover property ($changed(AMPLITUDE));
endmodule : bdsc_sva

bind bdsc_top bdsc_sva u_sva (.*);

// ==== bdsc_host.sv ====
// host model driving the serial pins of the block
// assumes callers keep frames apart; the link clock stands still between them
`timescale 1ns/10ps
module bdsc_host (
  output logic SCK,
  output logic CS_N,
  output logic SERIAL_IN,
  input wire logic SERIAL_OUT
);
  initial begin
    SCK = 1'b0;
    CS_N = 1'b1;
    SERIAL_IN = 1'b1;
  end
  // link logic only leaves reset on its own clock edges
  task automatic tick(input int n);
    repeat (n) begin
      #62.5 SCK = 1'b1;
      #62.5 SCK = 1'b0;
    end
  endtask : tick
  task automatic frame(input logic [15:0] w, output logic [15:0] rd);
    CS_N = 1'b0;
    #20;
    for (int i = 15; i >= 0; i--) begin
      SERIAL_IN = w[i];
      #62.5 SCK = 1'b1;
      rd[i] = SERIAL_OUT;
      #62.5 SCK = 1'b0;
    end
    #20 CS_N = 1'b1;
    SERIAL_IN = ~SERIAL_IN;
    #100;
  endtask : frame
endmodule : bdsc_host

// ==== tb_top.sv ====
// self-checking bench of the beamform driver serial control block
// assumes bdsc_host drives the serial pins and the bench all other inputs
`timescale 1ns/10ps
module tb_top;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  logic DAC_LOAD_STROBE = 1'b0;
  logic ENABLE = 1'b0;
  logic INPHASE_DRIVE_A = 1'b0;
  logic INPHASE_DRIVE_B = 1'b0;
  logic QUAD_DRIVE_A = 1'b0;
  logic QUAD_DRIVE_B = 1'b0;
  logic SCK, CS_N, SERIAL_IN, SERIAL_OUT, SINK_OUT_A, SINK_OUT_B, SINK_OE, POWER_DOWN;
  logic [7:0] AMPLITUDE;
  bdsc_pkg::bdsc_vec_t VECTOR;
  logic [15:0] rd;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  // amplitude, angle, vector; angles stay at or below 48
  logic [27:0] tbl [7] = '{28'hFF01F80, 28'h0005F08, 28'h80196AD, 28'h7F4B6AD,
    28'h017B6ED, 28'hFEBDF48, 28'hA5C1F80};
  bdsc_top DUT (.*);
  bdsc_host HOST (.*);
  always #5 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge CORE_CLK);
  endtask : wait_cyc
  task automatic load();
    wait_cyc(1);
    DAC_LOAD_STROBE = 1'b1;
    wait_cyc(8);
    DAC_LOAD_STROBE = 1'b0;
    wait_cyc(4);
  endtask : load
  initial begin
    HOST.tick(3);
    wait_cyc(1);
    RST = 1'b0;
    HOST.tick(3);
    // the tick ends on a core rising edge; step off it before sampling outputs
    wait_cyc(1);
    chk({SINK_OE, POWER_DOWN, 6'h00, AMPLITUDE}, 16'h0000);
    chk({2'b00, VECTOR}, 16'h1F80);
    for (int i = 0; i < 7; i++) begin
      HOST.frame({2'b00, tbl[i][27:14]}, rd);
      chk({8'h00, AMPLITUDE}, i == 0 ? 16'h0000 : {8'h00, tbl[i - 1][27:20]});
      load();
      chk({8'h00, AMPLITUDE}, {8'h00, tbl[i][27:20]});
      chk({2'b00, VECTOR}, {2'b00, tbl[i][13:0]});
    end
    HOST.frame(16'h4000, rd);
    HOST.frame(16'hCF05, rd);
    chk({1'b0, rd[14:0]}, 16'h6970);
    load();
    chk({8'h00, AMPLITUDE}, 16'h00A5);
    HOST.frame(16'h8000, rd);
    chk({15'h0000, POWER_DOWN}, 16'h0001);
    HOST.frame(16'hC000, rd);
    chk({15'h0000, POWER_DOWN}, 16'h0000);
    ENABLE = 1'b1;
    INPHASE_DRIVE_A = 1'b1;
    wait_cyc(1990);
    chk({15'h0000, SINK_OE}, 16'h0000);
    wait_cyc(20);
    chk({13'h0000, SINK_OE, SINK_OUT_A, SINK_OUT_B}, 16'h0006);
    INPHASE_DRIVE_A = 1'b0;
    QUAD_DRIVE_B = 1'b1;
    wait_cyc(5);
    chk({13'h0000, SINK_OE, SINK_OUT_A, SINK_OUT_B}, 16'h0005);
    QUAD_DRIVE_A = 1'b1;
    INPHASE_DRIVE_B = 1'b1;
    HOST.frame(16'h8000, rd);
    chk({14'h0000, SINK_OE, SINK_OUT_A}, 16'h0000);
    HOST.frame(16'hC000, rd);
    // power-up with enable still settled must drive both sinks again at once
    chk({13'h0000, SINK_OE, SINK_OUT_A, SINK_OUT_B}, 16'h0007);
    wait_cyc(1);
    ENABLE = 1'b0;
    wait_cyc(6);
    chk({13'h0000, SINK_OE, SINK_OUT_A, SINK_OUT_B}, 16'h0000);
    finish_test();
  end
endmodule : tb_top
